// ===== core/hseq_cfg.svh
// constants for the homing sequencer: method codes, conditions, resets
`ifndef HSEQ_CFG_SVH
`define HSEQ_CFG_SVH

// ============================================================
// method codes as selected by the host
`define HSEQ_METHOD_27 8'h1b
`define HSEQ_METHOD_28 8'h1c
`define HSEQ_METHOD_29 8'h1d
`define HSEQ_METHOD_30 8'h1e
`define HSEQ_METHOD_31 8'h1f
`define HSEQ_METHOD_32 8'h20
`define HSEQ_METHOD_33 8'h21

// ============================================================
// method table index
`define HSEQ_MI_27 3'h0
`define HSEQ_MI_28 3'h1
`define HSEQ_MI_29 3'h2
`define HSEQ_MI_30 3'h3
`define HSEQ_MI_33 3'h4

// ============================================================
// segment end conditions
`define HSEQ_COND_NONE 3'h0
`define HSEQ_COND_RISE 3'h1
`define HSEQ_COND_FALL 3'h2
`define HSEQ_COND_ON 3'h3
`define HSEQ_COND_OFF 3'h4
`define HSEQ_COND_INDEX 3'h5

// ============================================================
// search paths
`define HSEQ_PATH_POS 2'h0
`define HSEQ_PATH_NL 2'h1
`define HSEQ_PATH_ACT 2'h2

// ============================================================
// reset values
`define HSEQ_STEP_RST 2'h0
`define HSEQ_POS_RST 32'h0000_0000

`endif

// ===== core/hseq_pkg.sv
// types shared by the homing sequencer
package hseq_pkg;

    typedef enum logic [1:0] {
        HSEQ_IDLE,
        HSEQ_RUN,
        HSEQ_STOP
    } hseq_state_t;

    typedef logic [7:0] hseq_method_t;
    typedef logic [31:0] hseq_pos_t;

    typedef struct packed {
        logic valid;
        logic last;
        logic dir_pos;
        logic fast;
        logic [2:0] cond;
    } hseq_seg_t;

endpackage

// ===== core/hseq_top.sv
// homing sequencer for methods 27 to 30 and 33 of a servo axis
// Notes on behaviour
// RL1 - 27 inactive: negative fast, positive slow latch
// RL2 - 27 via limit: four segments, latch falling
// RL3 - 27 active: out positive, back, slow latch
// RL4 - 28 inactive: find, back out, negative slow
// RL5 - 28 via limit: reverse, out, negative slow
// RL6 - 28 active: positive fast out, negative slow
// RL7 - 29 inactive: pass switch, positive slow latch
// RL8 - 29 via limit: find, back out, slow
// RL9 - 29 active: negative out, positive slow latch
// RL10 - 30 inactive: pass, return in, negative slow
// RL11 - 30 via limit: find, negative slow latch
// RL12 - 30 active: out negative, return, slow
// RL13 - 27/33: first negative limit reverses, second alarms
// RL14 - 28-30: positive limit or second negative alarms
// RL15 - reserved methods 31, 32 refused with method error
// RL16 - 33: negative slow, latch at index
// RL17 - 33: limit first, then positive index search
// RL18 - full stop before reversal; latch ends run
`timescale 1ns/1ps
`include "hseq_cfg.svh"

module hseq_top (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic start_in,
    input wire hseq_pkg::hseq_method_t method_in,
    input wire logic home_switch_in,
    input wire logic negative_limit_in,
    input wire logic positive_limit_in,
    input wire logic index_pulse_in,
    input wire logic stopped_in,
    input wire hseq_pkg::hseq_pos_t position_in,
    output logic move_out,
    output logic dir_pos_out,
    output logic fast_out,
    output logic decel_out,
    output logic busy_out,
    output logic done_out,
    output logic alarm_out,
    output logic method_err_out,
    output logic origin_load_out,
    output hseq_pkg::hseq_pos_t origin_pos_out
);
    import hseq_pkg::*;

    // ============================================================
    // reset release
    // clocked release: no flop leaves reset a cycle ahead of another
    logic rst_meta_r;
    logic rst_b_r;

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_meta_r <= 1'b0;
            rst_b_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_b_r <= rst_meta_r;
        end
    end

    // ============================================================
    // segment table: method index, path, step -> one motion segment
    function automatic hseq_seg_t seg_lookup(input logic [2:0] mi,
            input logic [1:0] path, input logic [1:0] step);
        hseq_seg_t s;
        s = '0;
        case ({mi, path, step})
            // method 27
            {`HSEQ_MI_27, `HSEQ_PATH_POS, 2'h0}:
                s = {1'b1, 1'b0, 1'b0, 1'b1, `HSEQ_COND_RISE};
            {`HSEQ_MI_27, `HSEQ_PATH_POS, 2'h1}:
                s = {1'b1, 1'b1, 1'b1, 1'b0, `HSEQ_COND_FALL};
            {`HSEQ_MI_27, `HSEQ_PATH_NL, 2'h1}:
                s = {1'b1, 1'b0, 1'b1, 1'b1, `HSEQ_COND_FALL};
            {`HSEQ_MI_27, `HSEQ_PATH_NL, 2'h2}:
                s = {1'b1, 1'b0, 1'b0, 1'b1, `HSEQ_COND_ON};
            {`HSEQ_MI_27, `HSEQ_PATH_NL, 2'h3}:
                s = {1'b1, 1'b1, 1'b1, 1'b0, `HSEQ_COND_FALL};
            {`HSEQ_MI_27, `HSEQ_PATH_ACT, 2'h0}:
                s = {1'b1, 1'b0, 1'b1, 1'b1, `HSEQ_COND_FALL};
            {`HSEQ_MI_27, `HSEQ_PATH_ACT, 2'h1}:
                s = {1'b1, 1'b0, 1'b0, 1'b1, `HSEQ_COND_ON};
            {`HSEQ_MI_27, `HSEQ_PATH_ACT, 2'h2}:
                s = {1'b1, 1'b1, 1'b1, 1'b0, `HSEQ_COND_FALL};
            // method 28
            {`HSEQ_MI_28, `HSEQ_PATH_POS, 2'h0}:
                s = {1'b1, 1'b0, 1'b0, 1'b1, `HSEQ_COND_RISE};
            {`HSEQ_MI_28, `HSEQ_PATH_POS, 2'h1}:
                s = {1'b1, 1'b0, 1'b1, 1'b1, `HSEQ_COND_OFF};
            {`HSEQ_MI_28, `HSEQ_PATH_POS, 2'h2}:
                s = {1'b1, 1'b1, 1'b0, 1'b0, `HSEQ_COND_RISE};
            {`HSEQ_MI_28, `HSEQ_PATH_NL, 2'h1}:
                s = {1'b1, 1'b0, 1'b1, 1'b1, `HSEQ_COND_FALL};
            {`HSEQ_MI_28, `HSEQ_PATH_NL, 2'h2}:
                s = {1'b1, 1'b1, 1'b0, 1'b0, `HSEQ_COND_RISE};
            {`HSEQ_MI_28, `HSEQ_PATH_ACT, 2'h0}:
                s = {1'b1, 1'b0, 1'b1, 1'b1, `HSEQ_COND_FALL};
            {`HSEQ_MI_28, `HSEQ_PATH_ACT, 2'h1}:
                s = {1'b1, 1'b1, 1'b0, 1'b0, `HSEQ_COND_RISE};
            // method 29
            {`HSEQ_MI_29, `HSEQ_PATH_POS, 2'h0}:
                s = {1'b1, 1'b0, 1'b0, 1'b1, `HSEQ_COND_FALL};
            {`HSEQ_MI_29, `HSEQ_PATH_POS, 2'h1}:
                s = {1'b1, 1'b1, 1'b1, 1'b0, `HSEQ_COND_RISE};
            {`HSEQ_MI_29, `HSEQ_PATH_NL, 2'h1}:
                s = {1'b1, 1'b0, 1'b1, 1'b1, `HSEQ_COND_RISE};
            {`HSEQ_MI_29, `HSEQ_PATH_NL, 2'h2}:
                s = {1'b1, 1'b0, 1'b0, 1'b1, `HSEQ_COND_OFF};
            {`HSEQ_MI_29, `HSEQ_PATH_NL, 2'h3}:
                s = {1'b1, 1'b1, 1'b1, 1'b0, `HSEQ_COND_RISE};
            {`HSEQ_MI_29, `HSEQ_PATH_ACT, 2'h0}:
                s = {1'b1, 1'b0, 1'b0, 1'b1, `HSEQ_COND_FALL};
            {`HSEQ_MI_29, `HSEQ_PATH_ACT, 2'h1}:
                s = {1'b1, 1'b1, 1'b1, 1'b0, `HSEQ_COND_RISE};
            // method 30
            {`HSEQ_MI_30, `HSEQ_PATH_POS, 2'h0}:
                s = {1'b1, 1'b0, 1'b0, 1'b1, `HSEQ_COND_FALL};
            {`HSEQ_MI_30, `HSEQ_PATH_POS, 2'h1}:
                s = {1'b1, 1'b0, 1'b1, 1'b1, `HSEQ_COND_ON};
            {`HSEQ_MI_30, `HSEQ_PATH_POS, 2'h2}:
                s = {1'b1, 1'b1, 1'b0, 1'b0, `HSEQ_COND_FALL};
            {`HSEQ_MI_30, `HSEQ_PATH_NL, 2'h1}:
                s = {1'b1, 1'b0, 1'b1, 1'b1, `HSEQ_COND_RISE};
            {`HSEQ_MI_30, `HSEQ_PATH_NL, 2'h2}:
                s = {1'b1, 1'b1, 1'b0, 1'b0, `HSEQ_COND_FALL};
            {`HSEQ_MI_30, `HSEQ_PATH_ACT, 2'h0}:
                s = {1'b1, 1'b0, 1'b0, 1'b1, `HSEQ_COND_FALL};
            {`HSEQ_MI_30, `HSEQ_PATH_ACT, 2'h1}:
                s = {1'b1, 1'b0, 1'b1, 1'b1, `HSEQ_COND_ON};
            {`HSEQ_MI_30, `HSEQ_PATH_ACT, 2'h2}:
                s = {1'b1, 1'b1, 1'b0, 1'b0, `HSEQ_COND_FALL};
            // method 33, switch level does not matter
            {`HSEQ_MI_33, `HSEQ_PATH_POS, 2'h0},
            {`HSEQ_MI_33, `HSEQ_PATH_ACT, 2'h0}:
                s = {1'b1, 1'b1, 1'b0, 1'b0, `HSEQ_COND_INDEX};
            {`HSEQ_MI_33, `HSEQ_PATH_NL, 2'h1}:
                s = {1'b1, 1'b1, 1'b1, 1'b0, `HSEQ_COND_INDEX};
            default:
                s = '0;
        endcase
        return s;
    endfunction

    // ============================================================
    // state
    hseq_state_t state_r, state_nxt;
    logic [2:0] mi_r, mi_nxt;
    logic [1:0] path_r, path_nxt;
    logic [1:0] step_r, step_nxt;
    logic finish_r, finish_nxt;
    logic abort_r, abort_nxt;
    logic nl_seen_r, nl_seen_nxt;
    logic alarm_r, alarm_nxt;
    logic merr_r, merr_nxt;
    logic hs_prev_r;
    logic idx_prev_r;
    hseq_pos_t idx_pos_r, idx_pos_nxt;
    hseq_pos_t origin_r, origin_nxt;
    logic load_nxt;
    logic done_nxt;

    // ============================================================
    // decoding
    wire hs_rise = home_switch_in & ~hs_prev_r;
    wire hs_fall = ~home_switch_in & hs_prev_r;
    wire idx_rise = index_pulse_in & ~idx_prev_r;
    wire hseq_seg_t seg = seg_lookup(mi_r, path_r, step_r);
    wire hseq_seg_t seg_nxt = seg_lookup(mi_nxt, path_nxt, step_nxt);
    wire pl_checked = (mi_r != `HSEQ_MI_27) && (mi_r != `HSEQ_MI_33);
    wire first_seg = (path_r == `HSEQ_PATH_POS) && (step_r == 2'h0);
    wire nl_hit = negative_limit_in && !seg.dir_pos;
    // only the opening segment of the inactive-switch path may turn at the limit; anywhere
    // else a limit hit counts as the second one
    wire nl_reverse = nl_hit && first_seg && !nl_seen_r; // [RL13] [RL17]
    wire pl_abort = positive_limit_in && pl_checked; // [RL14]
    wire nl_abort = nl_hit && !nl_reverse; // [RL13] [RL14]
    // a hole in the table stops the axis rather than run it blind
    wire seg_missing = !seg.valid;
    wire run_abort = pl_abort || nl_abort || seg_missing;
    wire idx_seg = (seg.cond == `HSEQ_COND_INDEX);
    wire use_idx = (mi_r == `HSEQ_MI_33);
    wire run_next = (state_nxt == HSEQ_RUN);
    wire stop_next = (state_nxt == HSEQ_STOP);
    wire idle_next = (state_nxt == HSEQ_IDLE);

    wire [2:0] start_mi =
        (method_in == `HSEQ_METHOD_27) ? `HSEQ_MI_27 :
        (method_in == `HSEQ_METHOD_28) ? `HSEQ_MI_28 :
        (method_in == `HSEQ_METHOD_29) ? `HSEQ_MI_29 :
        (method_in == `HSEQ_METHOD_30) ? `HSEQ_MI_30 : `HSEQ_MI_33;
    // reserved 31/32 and anything else start no motion
    wire start_ok = (method_in >= `HSEQ_METHOD_27 &&
                     method_in <= `HSEQ_METHOD_30) ||
                    method_in == `HSEQ_METHOD_33; // [RL15]
    wire start_path_act = home_switch_in && (start_mi != `HSEQ_MI_33);

    // return segments end on a level, so an overshot region still ends
    logic cond_met;
    always_comb begin
        case (seg.cond)
            `HSEQ_COND_RISE: cond_met = hs_rise;
            `HSEQ_COND_FALL: cond_met = hs_fall;
            `HSEQ_COND_ON: cond_met = home_switch_in;
            `HSEQ_COND_OFF: cond_met = ~home_switch_in;
            `HSEQ_COND_INDEX: cond_met = idx_rise; // [RL16] [RL17]
            default: cond_met = 1'b0;
        endcase
    end

    // ============================================================
    // sequencer
    always_comb begin
        state_nxt = state_r;
        mi_nxt = mi_r;
        path_nxt = path_r;
        step_nxt = step_r;
        finish_nxt = finish_r;
        abort_nxt = abort_r;
        nl_seen_nxt = nl_seen_r;
        alarm_nxt = alarm_r;
        merr_nxt = merr_r;
        idx_pos_nxt = idx_pos_r;
        origin_nxt = origin_r;
        load_nxt = 1'b0;
        done_nxt = 1'b0;
        case (state_r)
            HSEQ_IDLE: begin
                if (start_in) begin
                    alarm_nxt = 1'b0;
                    merr_nxt = !start_ok;
                    if (start_ok) begin
                        state_nxt = HSEQ_RUN;
                        mi_nxt = start_mi;
                        path_nxt = start_path_act ? `HSEQ_PATH_ACT :
                                                    `HSEQ_PATH_POS;
                        step_nxt = `HSEQ_STEP_RST;
                        finish_nxt = 1'b0;
                        abort_nxt = 1'b0;
                        nl_seen_nxt = 1'b0;
                    end
                end
            end
            HSEQ_RUN: begin
                // every exit goes through a full stop first
                if (run_abort) begin
                    abort_nxt = 1'b1; // [RL13] [RL14]
                    state_nxt = HSEQ_STOP;
                end else if (nl_reverse) begin
                    nl_seen_nxt = 1'b1; // [RL2] [RL5] [RL8] [RL11]
                    path_nxt = `HSEQ_PATH_NL;
                    step_nxt = 2'h1;
                    state_nxt = HSEQ_STOP; // [RL18]
                end else if (cond_met) begin
                    if (idx_seg) begin
                        idx_pos_nxt = position_in; // [RL16]
                    end
                    finish_nxt = seg.last;
                    if (!seg.last) begin
                        step_nxt = step_r + 2'h1;
                    end
                    state_nxt = HSEQ_STOP; // [RL18]
                end
            end
            HSEQ_STOP: begin
                if (stopped_in) begin
                    // alarm only once at rest; the axis never coasts on
                    if (abort_r) begin
                        alarm_nxt = 1'b1; // [RL13] [RL14]
                        state_nxt = HSEQ_IDLE;
                    end else if (finish_r) begin
                        // [RL1] [RL3] [RL4] [RL6] [RL7] [RL9]
                        // [RL10] [RL12]
                        origin_nxt = use_idx ? idx_pos_r :
                                     position_in; // [RL18]
                        load_nxt = 1'b1;
                        done_nxt = 1'b1;
                        state_nxt = HSEQ_IDLE;
                    end else begin
                        state_nxt = HSEQ_RUN;
                    end
                end
            end
            default: begin
                state_nxt = HSEQ_IDLE;
            end
        endcase
    end

    // ============================================================
    // registers; outputs all come from here
    always_ff @(posedge clock_in or negedge rst_b_r) begin
        if (!rst_b_r) begin
            state_r <= HSEQ_IDLE;
            mi_r <= `HSEQ_MI_27;
            path_r <= `HSEQ_PATH_POS;
            step_r <= `HSEQ_STEP_RST;
            finish_r <= 1'b0;
            abort_r <= 1'b0;
            nl_seen_r <= 1'b0;
            alarm_r <= 1'b0;
            merr_r <= 1'b0;
            hs_prev_r <= 1'b0;
            idx_prev_r <= 1'b0;
            idx_pos_r <= `HSEQ_POS_RST;
            origin_r <= `HSEQ_POS_RST;
            move_out <= 1'b0;
            dir_pos_out <= 1'b0;
            fast_out <= 1'b0;
            decel_out <= 1'b0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            origin_load_out <= 1'b0;
        end else begin
            state_r <= state_nxt;
            mi_r <= mi_nxt;
            path_r <= path_nxt;
            step_r <= step_nxt;
            finish_r <= finish_nxt;
            abort_r <= abort_nxt;
            nl_seen_r <= nl_seen_nxt;
            alarm_r <= alarm_nxt;
            merr_r <= merr_nxt;
            hs_prev_r <= home_switch_in;
            idx_prev_r <= index_pulse_in;
            idx_pos_r <= idx_pos_nxt;
            origin_r <= origin_nxt;
            move_out <= run_next;
            dir_pos_out <= seg_nxt.dir_pos;
            fast_out <= seg_nxt.fast;
            decel_out <= stop_next; // [RL18]
            busy_out <= !idle_next;
            done_out <= done_nxt;
            origin_load_out <= load_nxt;
        end
    end

    assign alarm_out = alarm_r;
    assign method_err_out = merr_r;
    assign origin_pos_out = origin_r;

endmodule // hseq_top

// ===== testbench/hseq_axis.sv
// behavioural axis with home switch, limits and index
`timescale 1ns/1ps
module hseq_axis (
    input wire logic clock_in,
    input wire logic move_in,
    input wire logic dir_pos_in,
    input wire logic fast_in,
    input wire logic load_in,
    input wire logic signed [31:0] load_pos_in,
    input wire logic signed [31:0] home_lo_in,
    input wire logic signed [31:0] home_hi_in,
    input wire logic [3:0] settle_in,
    output logic home_switch_out,
    output logic negative_limit_out,
    output logic positive_limit_out,
    output logic index_pulse_out,
    output logic stopped_out,
    output logic [31:0] position_out
);
    int pos_r = 0;
    logic [3:0] still_r = 4'h0;
    int step;
    assign step = (dir_pos_in ? 1 : -1) * (fast_in ? 8 : 1);
    always @(posedge clock_in) begin
        if (load_in) begin
            pos_r <= load_pos_in;
        end else if (move_in) begin
            pos_r <= pos_r + step;
        end
        still_r <= move_in ? 4'h0 : still_r + 4'(still_r != 4'hf);
    end
    // standstill only after a settle time, never while commanded
    assign stopped_out = !move_in && still_r >= settle_in;
    assign home_switch_out = pos_r >= home_lo_in && pos_r <= home_hi_in;
    assign negative_limit_out = pos_r <= 0;
    assign positive_limit_out = pos_r >= 4000;
    assign index_pulse_out = pos_r > 0 && pos_r % 256 == 0;
    assign position_out = pos_r;
endmodule // hseq_axis

// ===== testbench/hseq_bench.sv
// self-checking bench for the homing sequencer
`timescale 1ns/1ps
module hseq_bench;
    import hseq_pkg::*;
    logic clock_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic start_in = 1'b0;
    hseq_method_t method_in = 8'h00;
    logic load = 1'b0;
    logic [3:0] settle = 4'h1;
    logic signed [31:0] load_pos = 0;
    logic signed [31:0] home_lo = 0;
    logic signed [31:0] home_hi = 0;
    logic home, nlim, plim, index, stopped, move, dir_pos, fast, decel;
    logic busy, done, alarm, method_err, origin_load;
    hseq_pos_t position, origin_pos;
    logic [7:0] rnd = 8'h15;
    int failures = 0;
    int total_checks = 0;
    int exp_q[$];
    hseq_top DUT (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .start_in(start_in), .method_in(method_in), .home_switch_in(home),
        .negative_limit_in(nlim), .positive_limit_in(plim),
        .index_pulse_in(index), .stopped_in(stopped), .position_in(position),
        .move_out(move), .dir_pos_out(dir_pos), .fast_out(fast),
        .decel_out(decel), .busy_out(busy), .done_out(done),
        .alarm_out(alarm), .method_err_out(method_err),
        .origin_load_out(origin_load), .origin_pos_out(origin_pos));
    hseq_axis u_axis (.clock_in(clock_in), .move_in(move),
        .dir_pos_in(dir_pos), .fast_in(fast), .load_in(load),
        .load_pos_in(load_pos), .home_lo_in(home_lo), .home_hi_in(home_hi),
        .settle_in(settle), .home_switch_out(home), .negative_limit_out(nlim),
        .positive_limit_out(plim), .index_pulse_out(index),
        .stopped_out(stopped), .position_out(position));
    initial begin
        forever #2 clock_in = ~clock_in;
    end
    // ============================================================
    // shared tasks
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic tick();
        @(posedge clock_in);
        #1;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // segment codes {dir, fast}, first segment in the low bits
    task automatic run_case(input hseq_method_t m, input int p0, input int lo,
        input int hi, input int n, input logic [7:0] segs, input logic fin,
        input logic alm);
        int cyc;
        logic prev;
        exp_q = {};
        for (int i = 0; i < n; i++) begin
            exp_q.push_back(segs[2*i +: 2]);
        end
        rnd = lfsr(rnd);
        load_pos = p0 + rnd[1:0];
        home_lo = lo;
        home_hi = hi;
        load = 1'b1;
        tick();
        load = 1'b0;
        start_in = 1'b1;
        method_in = m;
        tick();
        start_in = 1'b0;
        prev = 1'b0;
        cyc = 0;
        while (!done && !alarm && cyc < 20000) begin
            if (move && !prev) begin
                check({30'h0, dir_pos, fast},
                      exp_q.size() ? exp_q.pop_front() : 9);
                rnd = lfsr(rnd);
                settle = 4'h1 + 4'(rnd[2:0]);
            end
            // a start while busy must leave no trace
            start_in = cyc == 6;
            method_in = 8'h1f;
            prev = move;
            cyc++;
            tick();
        end
        if (cyc >= 20000) begin
            failures++;
            give_verdict();
        end
        check(alarm, alm);
        check(method_err, 1'b0);
        check(exp_q.size(), 0);
        if (!alm) begin
            check(origin_load, 1'b1);
            check(origin_pos, m == 8'h21 ? 256 : position);
            check(home, fin);
        end
        $display("test method %0d from %0d ends", m, p0);
    endtask
    // ============================================================
    // main sequence
    initial begin
        logic [7:0] bad [3];
        bad = '{8'h1f, 8'h20, 8'h05};
        repeat (2) @(posedge clock_in);
        #1 rst_b_in = 1'b1;
        repeat (4) tick();
        check({move, busy, done, alarm, method_err, origin_load}, 0);
        for (int k = 0; k < 3; k++) begin
            start_in = 1'b1;
            method_in = bad[k];
            tick();
            start_in = 1'b0;
            check({busy, method_err, move}, 3'b010);
            tick();
        end
        $display("test reserved methods ends");
        run_case(8'h1b, 2500, 1500, 1800, 2, 8'h09, 1'b0, 1'b0);
        run_case(8'h1b, 800, 1500, 1800, 4, 8'h9d, 1'b0, 1'b0);
        run_case(8'h1b, 1650, 1500, 1800, 3, 8'h27, 1'b0, 1'b0);
        run_case(8'h1c, 2500, 1500, 1800, 3, 8'h0d, 1'b1, 1'b0);
        run_case(8'h1c, 800, 1500, 1800, 3, 8'h0d, 1'b1, 1'b0);
        run_case(8'h1c, 1650, 1500, 1800, 2, 8'h03, 1'b1, 1'b0);
        run_case(8'h1d, 2500, 1500, 1800, 2, 8'h09, 1'b1, 1'b0);
        run_case(8'h1d, 800, 1500, 1800, 4, 8'h9d, 1'b1, 1'b0);
        run_case(8'h1d, 1650, 1500, 1800, 2, 8'h09, 1'b1, 1'b0);
        run_case(8'h1e, 2500, 1500, 1800, 3, 8'h0d, 1'b0, 1'b0);
        run_case(8'h1e, 800, 1500, 1800, 3, 8'h0d, 1'b0, 1'b0);
        run_case(8'h1e, 1650, 1500, 1800, 3, 8'h0d, 1'b0, 1'b0);
        run_case(8'h21, 300, 1500, 1800, 1, 8'h00, 1'b0, 1'b0);
        run_case(8'h21, 100, 1500, 1800, 2, 8'h08, 1'b0, 1'b0);
        // switch out of reach: the positive limit ends the run
        run_case(8'h1c, 800, 5000, 5000, 2, 8'h0d, 1'b0, 1'b1);
        run_case(8'h1d, 800, 5000, 5000, 2, 8'h0d, 1'b0, 1'b1);
        run_case(8'h1e, 800, 5000, 5000, 2, 8'h0d, 1'b0, 1'b1);
        give_verdict();
    end
endmodule // hseq_bench

// ===== testbench/hseq_props.sv
// concurrent checks on the homing sequencer ports
`timescale 1ns/1ps
module hseq_props (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic start_in,
    input wire hseq_pkg::hseq_method_t method_in,
    input wire logic home_switch_in,
    input wire logic negative_limit_in,
    input wire logic positive_limit_in,
    input wire logic index_pulse_in,
    input wire logic stopped_in,
    input wire hseq_pkg::hseq_pos_t position_in,
    input wire logic move_out,
    input wire logic dir_pos_out,
    input wire logic fast_out,
    input wire logic decel_out,
    input wire logic busy_out,
    input wire logic done_out,
    input wire logic alarm_out,
    input wire logic method_err_out,
    input wire logic origin_load_out,
    input wire hseq_pkg::hseq_pos_t origin_pos_out
);
    import hseq_pkg::*;
    // ============================================================
    // helper state
    hseq_method_t m_r;
    hseq_pos_t idx_r;
    logic idx_d;
    logic take;
    logic ok_m;
    logic first_pos;
    logic pl_m;
    assign take = start_in && !busy_out;
    assign ok_m = method_in inside {8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h21};
    assign first_pos = home_switch_in && method_in inside {8'h1b, 8'h1c};
    assign pl_m = m_r inside {8'h1c, 8'h1d, 8'h1e};
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            m_r <= 8'h00;
            idx_d <= 1'b0;
            idx_r <= 32'h0000_0000;
        end else begin
            m_r <= take ? method_in : m_r;
            idx_d <= index_pulse_in;
            // last index edge seen; the axis holds still after the latch
            idx_r <= (index_pulse_in && !idx_d) ? position_in : idx_r;
        end
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    // ============================================================
    // sequences and assertions
    sequence s_take_ok;
        take && ok_m;
    endsequence
    sequence s_pl_hit;
        move_out && pl_m && $rose(positive_limit_in);
    endsequence
    sequence s_nl_hit33;
        move_out && !dir_pos_out && m_r == 8'h21 && $rose(negative_limit_in);
    endsequence
    sequence s_nl_first;
        move_out && !dir_pos_out && m_r inside {8'h1b, 8'h21}
            && $rose(negative_limit_in);
    endsequence
    a_first_segment: assert property (s_take_ok |=>
        move_out && busy_out
        && dir_pos_out == $past(first_pos)
        && fast_out == $past(method_in != 8'h21))
        else $error("first segment wrong");
    a_reserved_refused: assert property (take && !ok_m |=>
        method_err_out && !busy_out && !move_out)
        else $error("reserved method not refused");
    a_no_turn_moving: assert property (move_out && $past(move_out)
        |-> $stable(dir_pos_out) && $stable(fast_out))
        else $error("direction changed without stop");
    a_decel_waits: assert property (decel_out && !stopped_in |=>
        decel_out && !move_out)
        else $error("left stop before standstill");
    a_done_clean: assert property (done_out |->
        origin_load_out && !busy_out && !alarm_out)
        else $error("done without load or with alarm");
    a_origin_stop: assert property (done_out && m_r != 8'h21 |->
        origin_pos_out == $past(position_in))
        else $error("origin not stop position");
    a_origin_index: assert property (done_out && m_r == 8'h21 |->
        origin_pos_out == idx_r)
        else $error("origin not index position");
    a_index_slow: assert property (move_out && m_r == 8'h21
        |-> !fast_out)
        else $error("index search not slow");
    a_pl_abort: assert property (s_pl_hit |=> decel_out && !move_out)
        else $error("positive limit not stopping");
    a_alarm_no_done: assert property ($rose(alarm_out) |->
        !done_out && !busy_out)
        else $error("alarm with done or busy");
    a_nl_reverse: assert property (s_nl_hit33 |=>
        decel_out && !move_out)
        else $error("negative limit not stopping");
    a_nl_first_turn: assert property (s_nl_first |=>
        decel_out ##[1:20] (move_out && dir_pos_out))
        else $error("first negative limit not reversed");
endmodule // hseq_props

bind hseq_top hseq_props u_props (.*);
